// file: hdl/pcg_pkg.sv
package pcg_pkg;

  // ********************************************************************
  // Register numbers
  // ********************************************************************
  localparam logic [7:0] REG_INPUT_CONTROL = 8'h00;
  localparam logic [7:0] REG_LOOP_CONTROL = 8'h01;
  localparam logic [7:0] REG_DIV_LOW = 8'h02;
  localparam logic [7:0] REG_DIV_HIGH = 8'h03;
  localparam logic [7:0] REG_PHASE_OFFSET = 8'h04;
  localparam logic [7:0] REG_PHASE_ADJUST = 8'h05;
  localparam logic [7:0] REG_OUTPUT_ENABLE = 8'h06;
  localparam logic [7:0] REG_OSC_DIVIDER = 8'h07;
  localparam logic [7:0] REG_RESET = 8'h08;
  localparam logic [7:0] REG_CHIP_VERSION = 8'h10;
  localparam logic [7:0] REG_CHIP_REVISION = 8'h11;
  localparam logic [7:0] REG_STATUS = 8'h12;

  // ********************************************************************
  // Reset values and writable-bit masks
  // ********************************************************************
  localparam logic [7:0] RST_INPUT_CONTROL = 8'h41;
  localparam logic [7:0] RST_LOOP_CONTROL = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'hFF;
  localparam logic [3:0] RST_DIV_HIGH = 4'hF;
  localparam logic [7:0] RST_PHASE_OFFSET = 8'h00;
  localparam logic [1:0] RST_STEP_RES = 2'h3;
  localparam logic [5:0] RST_METAL = 6'h00;
  localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_OSC_DIVIDER = 8'h80;
  localparam logic [7:0] MASK_LOOP_CONTROL = 8'h37;
  localparam logic [7:0] MASK_PHASE_OFFSET = 8'hBF;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_DET_SOURCE = 0;
  localparam int BIT_DET_POLARITY = 1;
  localparam int BIT_REF_EDGE = 2;
  localparam int BIT_FB_EDGE = 3;
  localparam int BIT_FB_SOURCE = 4;
  localparam int BIT_AUX_SOURCE = 5;
  localparam int BIT_LOOP_LOCK_EN = 6;
  localparam int BIT_PHASE_LOCK_EN = 7;
  localparam int BIT_FILTER_SEL = 7;
  localparam int BIT_INPUT_SEL = 7;
  localparam int BIT_PCLK_EN = 0;

  // ********************************************************************
  // Bus address, reset command and divider constants
  // ********************************************************************
  localparam logic [6:0] DEV_ADDR_BASE = 7'h26;
  localparam logic [3:0] PLL_LOAD_CODE = 4'h5;
  localparam logic [3:0] DPA_LOAD_CODE = 4'hA;
  localparam logic [12:0] FB_MODULUS_OFFSET = 13'h0008;

  // ********************************************************************
  // Synchroniser lanes
  // ********************************************************************
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_ADDR = 2;
  localparam int SYN_DET = 3;
  localparam int SYN_PLL_LOCK = 4;
  localparam int SYN_DPA_LOCK = 5;
  localparam int SYN_REF = 6;
  localparam int SYN_RECOV = 7;
  localparam int SYN_OSC = 8;
  localparam int SYN_W = 9;

  typedef enum logic [3:0] {
    PCG_IDLE, PCG_ADDR, PCG_ACK_ADDR, PCG_PTR, PCG_ACK_PTR,
    PCG_WDATA, PCG_ACK_WDATA, PCG_RDATA, PCG_ACK_RDATA
  } pcg_state_t;

endpackage : pcg_pkg

// file: hdl/pcg_serial_regs.sv
// Overview of operation
// - Pin low: answer 4Dh read, 4Ch write
// - Pin high: answer 4Fh read, 4Eh write
// - Twelve registers: one WO, eight RW, three RO
// - Works with 100kHz and 400kHz bus clocks
// - Detector-enable source bit, reset one
// - Detector pin polarity bit, reset zero
// - Reference trigger edge select, reset zero
// - External feedback edge select, reset zero
// - Feedback source internal or external select
// - Aux sync from loop or input sync
// - Loop lock onto lock pin, reset one
// - Phase lock onto lock pin, reset zero
// - Post-scaler select field, reserved bits zero
// - Divider low byte, reset all ones
// - Divider high nibble, reset all ones
// - Six-bit phase offset steps, reset zero
// - Loop filter select bit, reset zero
// - Phase step resolution, reset three
// - Six-bit metal revision report field
// - Differential pixel clock enable, reset zero
// - Internal power-on reset sets all values
// - Upper nibble 5 loads loop working copies
// - Lower nibble A loads phase-adjust copy
// - Total division equals value plus eight
`timescale 1ns/1ps
`default_nettype none

module pcg_serial_regs
  import pcg_pkg::*;
#(
  // Arbitrary identification values.
  parameter logic [7:0] CHIP_VERSION = 8'h5A,
  parameter logic [7:0] CHIP_REVISION = 8'hA5,
  parameter logic [5:0] METAL_REV_MASK = 6'h3F
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic bus_address_select_pin_i,
  input wire logic detector_enable_pin_i,
  input wire logic pll_lock_i,
  input wire logic dpa_lock_i,
  input wire logic reference_sync_i,
  input wire logic recovered_sync_i,
  input wire logic osc_divided_i,
  output logic detector_active_o,
  output logic reference_edge_select_o,
  output logic feedback_edge_select_o,
  output logic feedback_source_select_o,
  output logic aux_sync_output_o,
  output logic lock_ref_o,
  output logic [2:0] detector_gain_o,
  output logic [1:0] post_scaler_select_o,
  output logic [7:0] divider_low_bits_o,
  output logic [3:0] divider_high_bits_o,
  output logic [12:0] feedback_modulus_o,
  output logic [5:0] phase_offset_steps_o,
  output logic loop_filter_select_o,
  output logic [1:0] phase_step_resolution_o,
  output logic diff_pixel_clock_enable_o,
  output logic [7:0] output_enable_bits_o,
  output logic [6:0] osc_divider_o,
  output logic input_select_o,
  output logic pll_reset_o,
  output logic phase_delay_unit_reset_o
);

  // ********************************************************************
  // State record
  // ********************************************************************
  typedef struct packed {
    pcg_state_t st;
    logic [SYN_W-1:0] sync1;
    logic [SYN_W-1:0] sync2;
    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic [7:0] ptr;
    logic rw;
    logic ack_on;
    logic sda_low;
    logic [7:0] in_ctrl;
    logic [7:0] loop_sh;
    logic [7:0] div_lo_sh;
    logic [3:0] div_hi_sh;
    logic [7:0] ofs;
    logic [1:0] res_sh;
    logic [5:0] metal;
    logic [7:0] oe;
    logic [7:0] osc;
    logic [7:0] loop_wk;
    logic [7:0] div_lo_wk;
    logic [3:0] div_hi_wk;
    logic [1:0] res_wk;
    logic [12:0] fb_mod;
    logic pll_pulse;
    logic dpa_pulse;
    logic det_act;
    logic aux;
    logic lock_ref;
  } pcg_regs_t;

  pcg_regs_t cur_ff;
  pcg_regs_t nxt_cur;

  logic [SYN_W-1:0] pins;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rx_byte;
  logic [7:0] rd_data;
  logic [6:0] own_addr;

  always_comb begin
    pins = '0;
    pins[SYN_SCL] = scl_i;
    pins[SYN_SDA] = sda_i;
    pins[SYN_ADDR] = bus_address_select_pin_i;
    pins[SYN_DET] = detector_enable_pin_i;
    pins[SYN_PLL_LOCK] = pll_lock_i;
    pins[SYN_DPA_LOCK] = dpa_lock_i;
    pins[SYN_REF] = reference_sync_i;
    pins[SYN_RECOV] = recovered_sync_i;
    pins[SYN_OSC] = osc_divided_i;
  end

  // ********************************************************************
  // Bus events
  // ********************************************************************
  // Sampling at 250 MHz gives hundreds of samples per bus bit at either
  // bus rate, so start, stop and edges are caught without a filter.
  // oversampled edges
  assign scl_s = cur_ff.sync2[SYN_SCL];
  assign sda_s = cur_ff.sync2[SYN_SDA];
  assign scl_rise = scl_s & ~cur_ff.scl_d;
  assign scl_fall = ~scl_s & cur_ff.scl_d;
  assign bus_start = scl_s & cur_ff.scl_d & cur_ff.sda_d & ~sda_s;
  assign bus_stop = scl_s & cur_ff.scl_d & ~cur_ff.sda_d & sda_s;
  assign rx_byte = {cur_ff.shreg[6:0], sda_s};
  assign own_addr = {DEV_ADDR_BASE[6:1], cur_ff.sync2[SYN_ADDR]};

  // ********************************************************************
  // Read decode
  // ********************************************************************
  always_comb begin
    case (cur_ff.ptr)
      REG_INPUT_CONTROL: rd_data = cur_ff.in_ctrl;
      REG_LOOP_CONTROL: rd_data = cur_ff.loop_sh;
      REG_DIV_LOW: rd_data = cur_ff.div_lo_sh;
      REG_DIV_HIGH: rd_data = {4'h0, cur_ff.div_hi_sh};
      REG_PHASE_OFFSET: rd_data = cur_ff.ofs;
      REG_PHASE_ADJUST: rd_data = {cur_ff.metal & METAL_REV_MASK, cur_ff.res_sh};
      REG_OUTPUT_ENABLE: rd_data = cur_ff.oe;
      REG_OSC_DIVIDER: rd_data = cur_ff.osc;
      REG_CHIP_VERSION: rd_data = CHIP_VERSION;
      REG_CHIP_REVISION: rd_data = CHIP_REVISION;
      REG_STATUS: rd_data = {6'h00, cur_ff.sync2[SYN_PLL_LOCK], cur_ff.sync2[SYN_DPA_LOCK]};
      default: rd_data = 8'h00;
    endcase
  end

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.sync1 = pins;
    nxt_cur.sync2 = cur_ff.sync1;
    nxt_cur.scl_d = scl_s;
    nxt_cur.sda_d = sda_s;
    nxt_cur.pll_pulse = 1'b0;
    nxt_cur.dpa_pulse = 1'b0;

    case (cur_ff.st)
      PCG_IDLE: begin
        nxt_cur.sda_low = 1'b0;
      end
      PCG_ADDR, PCG_PTR, PCG_WDATA: begin
        if (scl_rise) begin
          nxt_cur.shreg = rx_byte;
          nxt_cur.bitcnt = cur_ff.bitcnt + 3'h1;
          nxt_cur.ack_on = 1'b0;
          if (cur_ff.bitcnt == 3'h7) begin
            if (cur_ff.st == PCG_ADDR) begin
              if (rx_byte[7:1] == own_addr) begin
                nxt_cur.rw = rx_byte[0];
                nxt_cur.st = PCG_ACK_ADDR;
              end else begin
                nxt_cur.st = PCG_IDLE;
              end
            end else if (cur_ff.st == PCG_PTR) begin
              nxt_cur.ptr = rx_byte;
              nxt_cur.st = PCG_ACK_PTR;
            end else begin
              nxt_cur.ptr = cur_ff.ptr + 8'h01;
              nxt_cur.st = PCG_ACK_WDATA;
              case (cur_ff.ptr)
                REG_INPUT_CONTROL: nxt_cur.in_ctrl = rx_byte;
                REG_LOOP_CONTROL: nxt_cur.loop_sh = rx_byte & MASK_LOOP_CONTROL;
                REG_DIV_LOW: nxt_cur.div_lo_sh = rx_byte;
                REG_DIV_HIGH: nxt_cur.div_hi_sh = rx_byte[3:0];
                REG_PHASE_OFFSET: nxt_cur.ofs = rx_byte & MASK_PHASE_OFFSET;
                REG_PHASE_ADJUST: begin
                  nxt_cur.res_sh = rx_byte[1:0];
                  nxt_cur.metal = rx_byte[7:2];
                end
                REG_OUTPUT_ENABLE: nxt_cur.oe = rx_byte;
                REG_OSC_DIVIDER: nxt_cur.osc = rx_byte;
                REG_RESET: begin
                  if (rx_byte[7:4] == PLL_LOAD_CODE) begin
                    nxt_cur.loop_wk = cur_ff.loop_sh;
                    nxt_cur.div_lo_wk = cur_ff.div_lo_sh;
                    nxt_cur.div_hi_wk = cur_ff.div_hi_sh;
                    nxt_cur.fb_mod = {1'b0, cur_ff.div_hi_sh, cur_ff.div_lo_sh}
                      + FB_MODULUS_OFFSET;
                    nxt_cur.pll_pulse = 1'b1;
                  end
                  if (rx_byte[3:0] == DPA_LOAD_CODE) begin
                    nxt_cur.res_wk = cur_ff.res_sh;
                    nxt_cur.dpa_pulse = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
      end
      PCG_ACK_ADDR, PCG_ACK_PTR, PCG_ACK_WDATA: begin
        // The first falling edge opens the acknowledge slot, the second
        // closes it, so the line is never released while the clock is high.
        if (scl_fall && !cur_ff.ack_on) begin
          nxt_cur.sda_low = 1'b1;
          nxt_cur.ack_on = 1'b1;
        end else if (scl_fall) begin
          nxt_cur.ack_on = 1'b0;
          nxt_cur.bitcnt = 3'h0;
          if (cur_ff.st == PCG_ACK_ADDR && cur_ff.rw) begin
            nxt_cur.shreg = rd_data;
            nxt_cur.sda_low = ~rd_data[7];
            nxt_cur.ptr = cur_ff.ptr + 8'h01;
            nxt_cur.st = PCG_RDATA;
          end else begin
            nxt_cur.sda_low = 1'b0;
            nxt_cur.st = (cur_ff.st == PCG_ACK_ADDR) ? PCG_PTR : PCG_WDATA;
          end
        end
      end
      PCG_RDATA: begin
        if (scl_rise) begin
          nxt_cur.bitcnt = cur_ff.bitcnt + 3'h1;
          if (cur_ff.bitcnt == 3'h7) begin
            nxt_cur.ack_on = 1'b0;
            nxt_cur.st = PCG_ACK_RDATA;
          end
        end else if (scl_fall) begin
          nxt_cur.shreg = {cur_ff.shreg[6:0], 1'b0};
          nxt_cur.sda_low = ~cur_ff.shreg[6];
        end
      end
      PCG_ACK_RDATA: begin
        if (scl_fall && !cur_ff.ack_on) begin
          nxt_cur.sda_low = 1'b0;
          nxt_cur.ack_on = 1'b1;
        end else if (scl_rise && cur_ff.ack_on && sda_s) begin
          // A refused byte ends the read; the stop or a new start follows.
          nxt_cur.st = PCG_IDLE;
        end else if (scl_fall) begin
          nxt_cur.ack_on = 1'b0;
          nxt_cur.bitcnt = 3'h0;
          nxt_cur.shreg = rd_data;
          nxt_cur.sda_low = ~rd_data[7];
          nxt_cur.ptr = cur_ff.ptr + 8'h01;
          nxt_cur.st = PCG_RDATA;
        end
      end
      default: begin
        nxt_cur.st = PCG_IDLE;
      end
    endcase

    // Start and stop win over any byte in progress.
    if (bus_start) begin
      nxt_cur.st = PCG_ADDR;
      nxt_cur.bitcnt = 3'h0;
      nxt_cur.sda_low = 1'b0;
      nxt_cur.ack_on = 1'b0;
    end else if (bus_stop) begin
      nxt_cur.st = PCG_IDLE;
      nxt_cur.sda_low = 1'b0;
    end

    nxt_cur.det_act = cur_ff.in_ctrl[BIT_DET_SOURCE]
      | (cur_ff.sync2[SYN_DET] ^ cur_ff.in_ctrl[BIT_DET_POLARITY]);
    nxt_cur.aux = cur_ff.in_ctrl[BIT_AUX_SOURCE] ? cur_ff.sync2[SYN_REF]
      : cur_ff.sync2[SYN_RECOV];
    case ({cur_ff.in_ctrl[BIT_LOOP_LOCK_EN], cur_ff.in_ctrl[BIT_PHASE_LOCK_EN]})
      2'b01: nxt_cur.lock_ref = cur_ff.sync2[SYN_DPA_LOCK];
      2'b10: nxt_cur.lock_ref = cur_ff.sync2[SYN_PLL_LOCK];
      2'b11: nxt_cur.lock_ref = cur_ff.osc[BIT_INPUT_SEL] ? cur_ff.sync2[SYN_OSC]
        : (cur_ff.sync2[SYN_REF] ^ cur_ff.in_ctrl[BIT_REF_EDGE]);
      default: nxt_cur.lock_ref = 1'b0;
    endcase
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  // rst_i stands for the internal power-on detector; no pin resets it.
  // power-on values
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_ff <= '{
        st: PCG_IDLE,
        sync1: '1,
        sync2: '1,
        scl_d: 1'b1,
        sda_d: 1'b1,
        shreg: 8'h00,
        bitcnt: 3'h0,
        ptr: 8'h00,
        rw: 1'b0,
        ack_on: 1'b0,
        sda_low: 1'b0,
        in_ctrl: RST_INPUT_CONTROL,
        loop_sh: RST_LOOP_CONTROL,
        div_lo_sh: RST_DIV_LOW,
        div_hi_sh: RST_DIV_HIGH,
        ofs: RST_PHASE_OFFSET,
        res_sh: RST_STEP_RES,
        metal: RST_METAL,
        oe: RST_OUTPUT_ENABLE,
        osc: RST_OSC_DIVIDER,
        loop_wk: RST_LOOP_CONTROL,
        div_lo_wk: RST_DIV_LOW,
        div_hi_wk: RST_DIV_HIGH,
        res_wk: RST_STEP_RES,
        fb_mod: {1'b0, RST_DIV_HIGH, RST_DIV_LOW} + FB_MODULUS_OFFSET,
        pll_pulse: 1'b0,
        dpa_pulse: 1'b0,
        det_act: 1'b1,
        aux: 1'b0,
        lock_ref: 1'b0
      };
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~cur_ff.sda_low;
  assign detector_active_o = cur_ff.det_act;
  assign reference_edge_select_o = cur_ff.in_ctrl[BIT_REF_EDGE];
  assign feedback_edge_select_o = cur_ff.in_ctrl[BIT_FB_EDGE];
  assign feedback_source_select_o = cur_ff.in_ctrl[BIT_FB_SOURCE];
  assign aux_sync_output_o = cur_ff.aux;
  assign lock_ref_o = cur_ff.lock_ref;
  assign detector_gain_o = cur_ff.loop_wk[2:0];
  assign post_scaler_select_o = cur_ff.loop_wk[5:4];
  assign divider_low_bits_o = cur_ff.div_lo_wk;
  assign divider_high_bits_o = cur_ff.div_hi_wk;
  assign feedback_modulus_o = cur_ff.fb_mod;
  assign phase_offset_steps_o = cur_ff.ofs[5:0];
  assign loop_filter_select_o = cur_ff.ofs[BIT_FILTER_SEL];
  assign phase_step_resolution_o = cur_ff.res_wk;
  assign diff_pixel_clock_enable_o = cur_ff.oe[BIT_PCLK_EN];
  assign output_enable_bits_o = cur_ff.oe;
  assign osc_divider_o = cur_ff.osc[6:0];
  assign input_select_o = cur_ff.osc[BIT_INPUT_SEL];
  assign pll_reset_o = cur_ff.pll_pulse;
  assign phase_delay_unit_reset_o = cur_ff.dpa_pulse;

endmodule : pcg_serial_regs

`default_nettype wire

// file: verification/pcg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_host_model #(
  // about 398 kHz, inside the fast-mode limit
  parameter int QTR_CYCLES = 157
) (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output var logic scl_o,
  output var logic sda_low_o
);
  // ********
  // Bus phases of a quarter bit each
  // ********
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wait_q();
    repeat (QTR_CYCLES) @(negedge ref_clk_i);
  endtask : wait_q

  task automatic start_cond();
    sda_low_o = 1'b0;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_low_o = 1'b1;
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask : start_cond

  task automatic stop_cond();
    sda_low_o = 1'b1;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    sda_low_o = 1'b0;
    wait_q();
  endtask : stop_cond

  task automatic put_bit(input logic b, output logic r);
    sda_low_o = !b;
    wait_q();
    scl_o = 1'b1;
    wait_q();
    r = sda_i;
    wait_q();
    scl_o = 1'b0;
    wait_q();
  endtask : put_bit

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, r);
    ack = !r;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
    put_bit(last, r);
  endtask : recv_byte
endmodule : pcg_host_model
`default_nettype wire

// file: verification/pcg_serial_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pcg_serial_regs_monitor
  import pcg_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic detector_active_o,
  input wire logic [2:0] detector_gain_o,
  input wire logic [1:0] post_scaler_select_o,
  input wire logic [7:0] divider_low_bits_o,
  input wire logic [3:0] divider_high_bits_o,
  input wire logic [12:0] feedback_modulus_o,
  input wire logic [1:0] phase_step_resolution_o,
  input wire logic diff_pixel_clock_enable_o,
  input wire logic [7:0] output_enable_bits_o,
  input wire logic pll_reset_o,
  input wire logic phase_delay_unit_reset_o
);
  default clocking mon_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // ********
  // Load commands, working copies, enable bit, reset values and data line
  // ********
  sequence pll_load_s;
    pll_reset_o || $past(pll_reset_o) || $past(pll_reset_o, 2);
  endsequence
  sequence dpa_load_s;
    phase_delay_unit_reset_o || $past(phase_delay_unit_reset_o) ||
    $past(phase_delay_unit_reset_o, 2);
  endsequence

  loop_hold_a: assert property (
    $changed(feedback_modulus_o) || $changed(post_scaler_select_o) || $changed(detector_gain_o)
    |-> pll_load_s) else $error("loop working copy moved without a load");
  dpa_hold_a: assert property (
    $changed(phase_step_resolution_o) |-> dpa_load_s) else $error("resolution moved without a load");
  pll_pulse_a: assert property (
    pll_reset_o |=> !pll_reset_o) else $error("loop reset pulse too long");
  dpa_pulse_a: assert property (
    phase_delay_unit_reset_o |=> !phase_delay_unit_reset_o) else $error("phase reset pulse too long");
  modulus_sum_a: assert property (
    feedback_modulus_o == {1'b0, divider_high_bits_o, divider_low_bits_o} + FB_MODULUS_OFFSET)
    else $error("modulus is not divider plus offset");
  clock_enable_a: assert property (
    diff_pixel_clock_enable_o == output_enable_bits_o[BIT_PCLK_EN]) else $error("clock enable bit");
  reset_values_a: assert property (
    $fell(rst_i) |-> feedback_modulus_o == 13'h1007 && phase_step_resolution_o == RST_STEP_RES &&
    detector_active_o && !diff_pixel_clock_enable_o && sda_oe_n_o)
    else $error("wrong value after reset");
  take_low_a: assert property (
    $fell(sda_oe_n_o) |-> !scl_i && sda_o == 1'b0) else $error("data line taken while clock high");
  hold_low_a: assert property (
    $fell(sda_oe_n_o) |=> !sda_oe_n_o [*8]) else $error("data line released too soon");
endmodule : pcg_serial_regs_monitor

bind pcg_serial_regs pcg_serial_regs_monitor pcg_serial_regs_monitor_i (
  .ref_clk_i, .rst_i, .scl_i, .sda_o, .sda_oe_n_o, .detector_active_o, .detector_gain_o,
  .post_scaler_select_o, .divider_low_bits_o, .divider_high_bits_o, .feedback_modulus_o,
  .phase_step_resolution_o, .diff_pixel_clock_enable_o, .output_enable_bits_o, .pll_reset_o,
  .phase_delay_unit_reset_o
);
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pcg_pkg::*;
;
  logic ref_clk_i, rst_i, scl_w, host_low, sda_w, addr_pin, det_pin, pll_lock, ref_sync, rec_sync;
  logic sda_o, sda_oe_n_o, det_act, ref_edge, fb_edge, fb_src, aux, lock_ref, fil, diff_en, ack;
  logic [1:0] psel, res;
  logic [2:0] gain;
  logic [5:0] offs;
  logic [12:0] modulus;
  logic [7:0] rd;
  logic [7:0] wd [0:6];
  logic [7:0] tx [$];
  int err_total, n_tests;

  // The line is pulled up whenever neither party pulls it low.
  assign sda_w = host_low ? 1'b0 : (sda_oe_n_o ? 1'b1 : sda_o);
  always #2 ref_clk_i = ~ref_clk_i;

  pcg_host_model host_i (.ref_clk_i(ref_clk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_low_o(host_low));
  pcg_serial_regs pcg_serial_regs_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .bus_address_select_pin_i(addr_pin), .detector_enable_pin_i(det_pin),
    .pll_lock_i(pll_lock), .dpa_lock_i(1'b0), .reference_sync_i(ref_sync),
    .recovered_sync_i(rec_sync), .osc_divided_i(1'b0), .detector_active_o(det_act),
    .reference_edge_select_o(ref_edge), .feedback_edge_select_o(fb_edge),
    .feedback_source_select_o(fb_src), .aux_sync_output_o(aux), .lock_ref_o(lock_ref),
    .detector_gain_o(gain), .post_scaler_select_o(psel), .divider_low_bits_o(),
    .divider_high_bits_o(), .feedback_modulus_o(modulus), .phase_offset_steps_o(offs),
    .loop_filter_select_o(fil), .phase_step_resolution_o(res), .diff_pixel_clock_enable_o(diff_en),
    .output_enable_bits_o(), .osc_divider_o(), .input_select_o(), .pll_reset_o(),
    .phase_delay_unit_reset_o()
  );

  // ********
  // Checking and bus helpers
  // ********
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_val(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: value %0h, expected %0h", $time, got, exp);
    end
  endtask : cmp_val

  function automatic logic [7:0] exp_reg(input int r);
    case (r)
      1: return wd[1] & MASK_LOOP_CONTROL;
      3: return {4'h0, wd[3][3:0]};
      4: return wd[4] & MASK_PHASE_OFFSET;
      default: return wd[r];
    endcase
  endfunction : exp_reg

  function automatic logic [12:0] exp_mod();
    return {1'b0, wd[3][3:0], wd[2]} + FB_MODULUS_OFFSET;
  endfunction : exp_mod

  task automatic bus_write(input logic [7:0] dev);
    host_i.start_cond();
    host_i.send_byte(dev, ack);
    cmp_bit(ack, 1'b1);
    foreach (tx[i]) begin
      host_i.send_byte(tx[i], ack);
      cmp_bit(ack, 1'b1);
    end
    host_i.stop_cond();
  endtask : bus_write

  task automatic bus_read(input logic [7:0] ptr, input int n);
    host_i.start_cond();
    host_i.send_byte(8'h4C, ack);
    host_i.send_byte(ptr, ack);
    host_i.start_cond();
    host_i.send_byte(8'h4D, ack);
    cmp_bit(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_i.recv_byte(i == n - 1, rd);
      cmp_val({5'h00, rd}, {5'h00, exp_reg(ptr + i)});
    end
    host_i.stop_cond();
  endtask : bus_read

  task automatic drive_pins(input logic a, input logic b);
    det_pin = a;
    pll_lock = b;
    ref_sync = b;
    rec_sync = !b;
    repeat (8) @(negedge ref_clk_i);
  endtask : drive_pins

  // ********
  // Main sequence
  // ********
  initial begin
    ref_clk_i = 1'b0;
    rst_i = 1'b1;
    addr_pin = 1'b0;
    det_pin = 1'b0;
    pll_lock = 1'b1;
    ref_sync = 1'b0;
    rec_sync = 1'b1;
    err_total = 0;
    n_tests = 0;
    void'($urandom(22113));
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge ref_clk_i);
    cmp_bit(det_act, 1'b1);
    cmp_bit(ref_edge, 1'b0);
    cmp_bit(fb_edge, 1'b0);
    cmp_bit(fb_src, 1'b0);
    cmp_bit(aux, 1'b1);
    cmp_bit(lock_ref, 1'b1);
    cmp_val(modulus, 13'h1007);
    cmp_val(13'(offs), 13'h0000);
    cmp_bit(fil, 1'b0);
    cmp_val(13'(res), 13'h0003);
    cmp_bit(diff_en, 1'b0);
    foreach (wd[i]) wd[i] = 8'($urandom);
    wd[0][7:6] = 2'h1;
    wd[0][0] = 1'b0;
    wd[5][1:0] = 2'($urandom_range(0, 1));
    tx = {8'h00};
    foreach (wd[i]) tx.push_back(wd[i]);
    bus_write(8'h4C);
    cmp_bit(ref_edge, wd[0][2]);
    cmp_bit(fb_edge, wd[0][3]);
    cmp_bit(fb_src, wd[0][4]);
    cmp_val(13'(offs), 13'(wd[4][5:0]));
    cmp_bit(fil, wd[4][7]);
    cmp_bit(diff_en, wd[6][0]);
    cmp_val(modulus, 13'h1007);
    cmp_val(13'(res), 13'h0003);
    for (int k = 0; k < 4; k++) begin
      drive_pins(k[0], k[1]);
      cmp_bit(det_act, k[0] ^ wd[0][1]);
      cmp_bit(lock_ref, k[1]);
      cmp_bit(aux, wd[0][5] ? k[1] : !k[1]);
    end
    addr_pin = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    host_i.start_cond();
    host_i.send_byte(8'h4C, ack);
    cmp_bit(ack, 1'b0);
    host_i.stop_cond();
    tx = {8'h08, 8'h0A};
    bus_write(8'h4E);
    cmp_val(13'(res), 13'(wd[5][1:0]));
    cmp_val(modulus, 13'h1007);
    addr_pin = 1'b0;
    tx = {8'h08, 8'h50 | 8'($urandom_range(0, 9))};
    bus_write(8'h4C);
    cmp_val(modulus, exp_mod());
    cmp_val(13'(psel), 13'(wd[1][5:4]));
    cmp_val(13'(gain), 13'(wd[1][2:0]));
    bus_read(8'h01, 4);
    test_done();
  end

  // A stuck bus would otherwise hold the run forever; the whole sequence
  // needs about 136000 cycles at the fast bus rate.
  initial begin
    repeat (145000) @(posedge ref_clk_i);
    err_total++;
    $display("mismatch at %0t: run did not finish", $time);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
